// ### hdl/cmoc_pkg.sv
// Package: constants and types for the CAN operating-mode control block
package cmoc_pkg;

  // ----------------------------------------------------------------------
  // Register map (low address nibble decodes, high nibble is ignored)
  // ----------------------------------------------------------------------
  localparam logic [3:0] CMOC_STATUS_OFFSET = 4'hE;
  localparam logic [3:0] CMOC_CONTROL_OFFSET = 4'hF;

  // ----------------------------------------------------------------------
  // Field positions of the mode and clock control register
  // ----------------------------------------------------------------------
  localparam int CMOC_MODE_MSB = 7;
  localparam int CMOC_MODE_LSB = 5;
  localparam int CMOC_ABORT_BIT = 4;
  localparam int CMOC_UNUSED_BIT = 3;
  localparam int CMOC_CLOCK_OUTPUT_ENABLE_BIT = 2;
  localparam int CMOC_DIV_MSB = 1;
  localparam int CMOC_DIV_LSB = 0;

  // ----------------------------------------------------------------------
  // Mode encodings and reset values
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    CMOC_MODE_NORMAL = 3'h0,
    CMOC_MODE_SLEEP = 3'h1,
    CMOC_MODE_LOOPBACK = 3'h2,
    CMOC_MODE_LISTEN = 3'h3,
    CMOC_MODE_CONFIG = 3'h4
  } cmoc_mode_type;

  localparam logic [2:0] CMOC_MODE_RESET = 3'h4;
  localparam logic CMOC_ABORT_RESET = 1'b0;
  localparam logic CMOC_CLOCK_OUTPUT_ENABLE_RESET = 1'b1;
  localparam logic [1:0] CMOC_DIV_RESET = 2'h3;
  localparam logic [7:0] CMOC_READ_IDLE = 8'h00;

  // ----------------------------------------------------------------------
  // Clock output divider: half-period minus one, per divider code
  // ----------------------------------------------------------------------
  localparam logic [1:0] CMOC_DIV_BY1 = 2'h0;
  localparam logic [1:0] CMOC_HALF_DIV2 = 2'h0;
  localparam logic [1:0] CMOC_HALF_DIV4 = 2'h1;
  localparam logic [1:0] CMOC_HALF_DIV8 = 2'h3;

  // Bus level meaning no drive on the transmit pin
  localparam logic CMOC_RECESSIVE = 1'b1;

  // ----------------------------------------------------------------------
  // Mode-change sequencing states (Gray along stable -> wait)
  // ----------------------------------------------------------------------
  typedef enum logic {
    CMOC_MS_STABLE = 1'b0,
    CMOC_MS_WAIT = 1'b1
  } cmoc_mchg_type;

endpackage : cmoc_pkg

// ### hdl/cmoc_clock_output_pin_div.sv
// Clock output pin divider with glitch-free divider switching
`timescale 1ns/100ps
`default_nettype none
module cmoc_clock_output_pin_div (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic outputEnable,
  input wire logic [1:0] divideSelect,
  output logic clockOutputPin,
  output logic clockOutputPinEn
);

  logic [1:0] activeDiv_reg;
  logic [1:0] activeDiv_next;
  logic [1:0] count_reg;
  logic [1:0] count_next;
  logic level_reg;
  logic level_next;
  logic enable_reg;
  logic enable_next;

  // Half-period length minus one for one divider code
  function automatic logic [1:0] halfLength(input logic [1:0] code);
    case (code)
      2'h1: halfLength = cmoc_pkg::CMOC_HALF_DIV2;
      2'h2: halfLength = cmoc_pkg::CMOC_HALF_DIV4;
      2'h3: halfLength = cmoc_pkg::CMOC_HALF_DIV8;
      default: halfLength = cmoc_pkg::CMOC_HALF_DIV2;
    endcase
  endfunction : halfLength

  // Divider and enable only change at the end of a low phase, so no
  // shortened high or low time ever reaches the pin
  always_comb begin
    activeDiv_next = activeDiv_reg;
    count_next = count_reg;
    level_next = level_reg;
    enable_next = enable_reg;
    if (count_reg == halfLength(activeDiv_reg)) begin
      count_next = 2'h0;
      level_next = ~level_reg;
      if (!level_reg) begin
        activeDiv_next = divideSelect;
        enable_next = outputEnable;
      end
    end else begin
      count_next = count_reg + 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      activeDiv_reg <= cmoc_pkg::CMOC_DIV_RESET;
      count_reg <= 2'h0;
      level_reg <= 1'b0;
      enable_reg <= cmoc_pkg::CMOC_CLOCK_OUTPUT_ENABLE_RESET;
    end else begin
      activeDiv_reg <= activeDiv_next;
      count_reg <= count_next;
      level_reg <= level_next;
      enable_reg <= enable_next;
    end
  end

  // Divide by one can only be the oscillator itself; all others are flops
  assign clockOutputPin = (activeDiv_reg == cmoc_pkg::CMOC_DIV_BY1) ? clk : level_reg;
  assign clockOutputPinEn = enable_reg;

endmodule : cmoc_clock_output_pin_div
`default_nettype wire

// ### hdl/cmoc_mode_ctrl.sv
// Operating-mode control: control/status registers, mode sequencing, bus gating
`timescale 1ns/100ps
`default_nettype none
module cmoc_mode_ctrl (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic [7:0] regWriteData,
  input wire logic regRead,
  output logic [7:0] regReadData,
  input wire logic [2:0] interruptCode,
  input wire logic txPending,
  input wire logic engineTxBit,
  input wire logic busRxPin,
  output logic busTransmitPin,
  output logic rxPathBit,
  output logic txStartAllowed,
  output logic ackEnable,
  output logic errorSignalEnable,
  output logic ackErrorIgnore,
  output logic acceptErrorFrames,
  output logic filterEnable,
  output logic errorCounterHold,
  output logic abortAllTransmissions,
  output logic sleepActive,
  output logic [2:0] currentMode,
  output logic clockOutputPin,
  output logic clockOutputPinEn
);

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------

  // True for one of the five defined mode codes
  function automatic logic modeValid(input logic [2:0] code);
    modeValid = (code <= cmoc_pkg::CMOC_MODE_CONFIG);
  endfunction : modeValid

  // Address decode on the low nibble only
  function automatic logic hits(input logic [7:0] addr, input logic [3:0] offset);
    hits = (addr[3:0] == offset);
  endfunction : hits

  // True when the active mode equals one mode code
  function automatic logic modeIs(input logic [2:0] active, input logic [2:0] code);
    modeIs = (active == code);
  endfunction : modeIs

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  // Control register fields
  logic [2:0] modeRequest_reg;
  logic [2:0] modeRequest_next;
  logic abortRequest_reg;
  logic abortRequest_next;
  logic clockEnable_reg;
  logic clockEnable_next;
  logic [1:0] clockDivider_reg;
  logic [1:0] clockDivider_next;
  // Read data register and the two readable images
  logic [7:0] readData_reg;
  logic [7:0] readData_next;
  logic [7:0] controlImage;
  logic [7:0] statusImage;

  // Control register: invalid mode codes are dropped to keep the field sane
  always_comb begin
    modeRequest_next = modeRequest_reg;
    abortRequest_next = abortRequest_reg;
    clockEnable_next = clockEnable_reg;
    clockDivider_next = clockDivider_reg;
    if (regWrite && hits(regAddr, cmoc_pkg::CMOC_CONTROL_OFFSET)) begin
      if (modeValid(regWriteData[cmoc_pkg::CMOC_MODE_MSB:cmoc_pkg::CMOC_MODE_LSB])) begin
        modeRequest_next = regWriteData[cmoc_pkg::CMOC_MODE_MSB:cmoc_pkg::CMOC_MODE_LSB];
      end
      // Other fields land even when the mode code is dropped
      abortRequest_next = regWriteData[cmoc_pkg::CMOC_ABORT_BIT];
      clockEnable_next = regWriteData[cmoc_pkg::CMOC_CLOCK_OUTPUT_ENABLE_BIT];
      clockDivider_next = regWriteData[cmoc_pkg::CMOC_DIV_MSB:cmoc_pkg::CMOC_DIV_LSB];
    end
  end

  // Reset requests configuration with the clock output at its slowest
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      modeRequest_reg <= cmoc_pkg::CMOC_MODE_RESET;
      abortRequest_reg <= cmoc_pkg::CMOC_ABORT_RESET;
      clockEnable_reg <= cmoc_pkg::CMOC_CLOCK_OUTPUT_ENABLE_RESET;
      clockDivider_reg <= cmoc_pkg::CMOC_DIV_RESET;
    end else begin
      modeRequest_reg <= modeRequest_next;
      abortRequest_reg <= abortRequest_next;
      clockEnable_reg <= clockEnable_next;
      clockDivider_reg <= clockDivider_next;
    end
  end

  // ----------------------------------------------------------------------
  // Mode-change sequencing
  // ----------------------------------------------------------------------
  cmoc_pkg::cmoc_mchg_type changeState_reg;
  cmoc_pkg::cmoc_mchg_type changeState_next;
  logic [2:0] activeMode_reg;
  logic [2:0] activeMode_next;

  // A new request waits until the transmit buffers have drained
  always_comb begin
    changeState_next = changeState_reg;
    activeMode_next = activeMode_reg;
    case (changeState_reg)
      cmoc_pkg::CMOC_MS_STABLE: begin
        // Any difference starts a change
        if (modeRequest_reg != activeMode_reg) begin
          changeState_next = cmoc_pkg::CMOC_MS_WAIT;
        end
      end
      cmoc_pkg::CMOC_MS_WAIT: begin
        if (modeRequest_reg == activeMode_reg) begin
          // Request withdrawn back to the active mode
          changeState_next = cmoc_pkg::CMOC_MS_STABLE;
        end else if (!txPending) begin
          // Buffers drained, so the switch cannot cut a frame
          activeMode_next = modeRequest_reg;
          changeState_next = cmoc_pkg::CMOC_MS_STABLE;
        end
      end
      default: begin
        changeState_next = cmoc_pkg::CMOC_MS_STABLE;
      end
    endcase
  end

  // Sequencer resets straight into configuration
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      changeState_reg <= cmoc_pkg::CMOC_MS_STABLE;
      activeMode_reg <= cmoc_pkg::CMOC_MODE_RESET;
    end else begin
      changeState_reg <= changeState_next;
      activeMode_reg <= activeMode_next;
    end
  end

  // ----------------------------------------------------------------------
  // Register read path
  // ----------------------------------------------------------------------
  // Readable images; unimplemented bits tie to zero
  always_comb begin
    controlImage = cmoc_pkg::CMOC_READ_IDLE;
    controlImage[cmoc_pkg::CMOC_MODE_MSB:cmoc_pkg::CMOC_MODE_LSB] = modeRequest_reg;
    controlImage[cmoc_pkg::CMOC_ABORT_BIT] = abortRequest_reg;
    controlImage[cmoc_pkg::CMOC_UNUSED_BIT] = 1'b0;
    controlImage[cmoc_pkg::CMOC_CLOCK_OUTPUT_ENABLE_BIT] = clockEnable_reg;
    controlImage[cmoc_pkg::CMOC_DIV_MSB:cmoc_pkg::CMOC_DIV_LSB] = clockDivider_reg;
    // Bits 4 and 0 of the status read zero
    statusImage = cmoc_pkg::CMOC_READ_IDLE;
    statusImage[cmoc_pkg::CMOC_MODE_MSB:cmoc_pkg::CMOC_MODE_LSB] = activeMode_reg;
    statusImage[3:1] = interruptCode;
  end

  // Read data is held until the next read; unmapped nibbles answer zero
  always_comb begin
    readData_next = readData_reg;
    if (regRead) begin
      if (hits(regAddr, cmoc_pkg::CMOC_CONTROL_OFFSET)) begin
        readData_next = controlImage;
      end else if (hits(regAddr, cmoc_pkg::CMOC_STATUS_OFFSET)) begin
        readData_next = statusImage;
      end else begin
        readData_next = cmoc_pkg::CMOC_READ_IDLE;
      end
    end
  end

  // Held between reads, so a slow host always sees a steady byte
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      readData_reg <= cmoc_pkg::CMOC_READ_IDLE;
    end else begin
      readData_reg <= readData_next;
    end
  end

  // ----------------------------------------------------------------------
  // Bus gating per active mode
  // ----------------------------------------------------------------------
  // Mode decodes
  logic isNormal;
  logic isLoop;
  logic isListen;
  logic isConfig;
  // Registered pin, path and qualifier copies
  logic busTx_reg;
  logic busTx_next;
  logic rxPath_reg;
  logic rxPath_next;
  logic [8:0] flags_reg;
  logic [8:0] flags_next;

  // One-hot view of the active mode
  assign isNormal = modeIs(activeMode_reg, cmoc_pkg::CMOC_MODE_NORMAL);
  assign isLoop = modeIs(activeMode_reg, cmoc_pkg::CMOC_MODE_LOOPBACK);
  assign isListen = modeIs(activeMode_reg, cmoc_pkg::CMOC_MODE_LISTEN);
  assign isConfig = modeIs(activeMode_reg, cmoc_pkg::CMOC_MODE_CONFIG);

  // Only normal mode may pull the pin; every silent mode leaves it recessive
  always_comb begin
    busTx_next = cmoc_pkg::CMOC_RECESSIVE;
    if (isNormal) begin
      busTx_next = engineTxBit;
    end
    // Loopback feeds the receiver from our own transmitter
    rxPath_next = isLoop ? engineTxBit : busRxPin;
  end

  // Mode qualifiers to the protocol engine, registered with the pins
  always_comb begin
    // Active participation and transmission in normal mode only
    flags_next[0] = isNormal;
    flags_next[1] = isNormal;
    flags_next[2] = isNormal;
    // Silent-mode relaxations
    flags_next[3] = isLoop;
    flags_next[4] = isListen;
    // Filters stay in the path in every mode
    flags_next[5] = 1'b1;
    // Counters frozen while listen-only or configuring; loopback and sleep leave them running
    flags_next[6] = isListen | isConfig;
    // Host abort request and the sleep indication
    flags_next[7] = abortRequest_reg;
    flags_next[8] = modeIs(activeMode_reg, cmoc_pkg::CMOC_MODE_SLEEP);
  end

  // Pins reset recessive; only the counter hold is raised in reset
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      busTx_reg <= cmoc_pkg::CMOC_RECESSIVE;
      rxPath_reg <= cmoc_pkg::CMOC_RECESSIVE;
      flags_reg <= 9'h040;
    end else begin
      busTx_reg <= busTx_next;
      rxPath_reg <= rxPath_next;
      flags_reg <= flags_next;
    end
  end

  // Pin and path copies
  assign busTransmitPin = busTx_reg;
  assign rxPathBit = rxPath_reg;
  // Mode qualifiers to the protocol engine
  assign txStartAllowed = flags_reg[0];
  assign ackEnable = flags_reg[1];
  assign errorSignalEnable = flags_reg[2];
  assign ackErrorIgnore = flags_reg[3];
  assign acceptErrorFrames = flags_reg[4];
  assign filterEnable = flags_reg[5];
  assign errorCounterHold = flags_reg[6];
  assign abortAllTransmissions = flags_reg[7];
  assign sleepActive = flags_reg[8];
  // Register-side views
  assign currentMode = activeMode_reg;
  assign regReadData = readData_reg;

  // ----------------------------------------------------------------------
  // Clock output pin
  // ----------------------------------------------------------------------
  // Enable and divider reach the pin only at a safe point of the divider
  cmoc_clock_output_pin_div clockOut (
    .clk(clk),
    .reset_n(reset_n),
    .outputEnable(clockEnable_reg),
    .divideSelect(clockDivider_reg),
    .clockOutputPin(clockOutputPin),
    .clockOutputPinEn(clockOutputPinEn)
  );

endmodule : cmoc_mode_ctrl
`default_nettype wire

// ### hdl/cmoc_note_fix.sv
// Spare design file: holds no logic of its own

// ### test/cmoc_mode_ctrl_sva.sv
// Checker: port-level assertions for the mode control block
`timescale 1ns/100ps
`default_nettype none
module cmoc_mode_ctrl_sva (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic [7:0] regWriteData,
  input wire logic txPending,
  input wire logic engineTxBit,
  input wire logic busRxPin,
  input wire logic busTransmitPin,
  input wire logic rxPathBit,
  input wire logic txStartAllowed,
  input wire logic ackEnable,
  input wire logic errorSignalEnable,
  input wire logic ackErrorIgnore,
  input wire logic acceptErrorFrames,
  input wire logic filterEnable,
  input wire logic errorCounterHold,
  input wire logic abortAllTransmissions,
  input wire logic sleepActive,
  input wire logic [2:0] currentMode,
  input wire logic clockOutputPinEn
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Control write seen at the port
  logic ctrlWr;
  assign ctrlWr = regWrite && regAddr[3:0] == 4'hF;
  // ---------------------------------------------------------------
  // Mode request then two quiet cycles
  // ---------------------------------------------------------------
  sequence sModeReq;
    ctrlWr && regWriteData[7:5] <= 3'h4;
  endsequence
  sequence sQuiet;
    !txPending && !ctrlWr;
  endsequence
  AST_MODE_TAKE: assert property (sModeReq ##1 sQuiet ##1 sQuiet |=>
    currentMode == $past(regWriteData[7:5], 3)) else $error("mode not taken");
  AST_MODE_WAIT: assert property ($past(reset_n) && currentMode != $past(currentMode) |->
    !$past(txPending)) else $error("mode moved while sending");
  AST_TX_GATE: assert property ($past(reset_n) |->
    busTransmitPin == ($past(currentMode) == 3'h0 ? $past(engineTxBit) : 1'b1))
    else $error("transmit pin not gated");
  AST_RX_PATH: assert property ($past(reset_n) |->
    rxPathBit == ($past(currentMode) == 3'h2 ? $past(engineTxBit) : $past(busRxPin)))
    else $error("receive path wrong");
  AST_NORMAL_FLAGS: assert property ($past(reset_n) |->
    {txStartAllowed, ackEnable, errorSignalEnable} == {3{$past(currentMode) == 3'h0}})
    else $error("normal flags wrong");
  AST_QUIET_FLAGS: assert property ($past(reset_n) |->
    ackErrorIgnore == ($past(currentMode) == 3'h2) && acceptErrorFrames ==
    ($past(currentMode) == 3'h3) && errorCounterHold == ($past(currentMode) inside {3'h3, 3'h4}))
    else $error("mode flags wrong");
  AST_FILTER_ON: assert property ($past(reset_n) |-> filterEnable &&
    sleepActive == ($past(currentMode) == 3'h1)) else $error("filter or sleep flag wrong");
  AST_ABORT: assert property (ctrlWr |-> ##2
    abortAllTransmissions == $past(regWriteData[4], 2)) else $error("abort not followed");
  AST_CLK_RESET: assert property ($rose(reset_n) |-> clockOutputPinEn)
    else $error("clock pin off after reset");
endmodule : cmoc_mode_ctrl_sva
bind cmoc_mode_ctrl cmoc_mode_ctrl_sva uSva (
  .clk(clk),
  .reset_n(reset_n),
  .regAddr(regAddr),
  .regWrite(regWrite),
  .regWriteData(regWriteData),
  .txPending(txPending),
  .engineTxBit(engineTxBit),
  .busRxPin(busRxPin),
  .busTransmitPin(busTransmitPin),
  .rxPathBit(rxPathBit),
  .txStartAllowed(txStartAllowed),
  .ackEnable(ackEnable),
  .errorSignalEnable(errorSignalEnable),
  .ackErrorIgnore(ackErrorIgnore),
  .acceptErrorFrames(acceptErrorFrames),
  .filterEnable(filterEnable),
  .errorCounterHold(errorCounterHold),
  .abortAllTransmissions(abortAllTransmissions),
  .sleepActive(sleepActive),
  .currentMode(currentMode),
  .clockOutputPinEn(clockOutputPinEn)
);
`default_nettype wire

// ### test/cmoc_bus_partner.sv
// Partner model: protocol engine and one other node on the bus
`timescale 1ns/100ps
`default_nettype none
module cmoc_bus_partner (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic holdTx,
  input wire logic busTransmitPin,
  output logic txPending,
  output logic engineTxBit,
  output logic busRxPin
);
  logic [7:0] pat_reg;
  logic [7:0] pat_next;
  // Pattern moves every cycle so a stale bit never passes for a fresh one
  always_comb pat_next = {pat_reg[6:0], pat_reg[7] ^ pat_reg[5] ^ pat_reg[4] ^ pat_reg[3]};
  always_ff @(posedge clk) pat_reg <= reset_n ? pat_next : 8'hA5;
  // Wired-AND bus: a dominant zero from either node wins
  assign busRxPin = busTransmitPin & pat_reg[3];
  assign engineTxBit = pat_reg[0];
  assign txPending = holdTx;
endmodule : cmoc_bus_partner
`default_nettype wire

// ### test/cmoc_mode_ctrl_tb_top.sv
// Testbench: register, mode, abort and clock-output scenarios
`timescale 1ns/100ps
`default_nettype none
module cmoc_mode_ctrl_tb_top;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic regWrite = 1'b0;
  logic [7:0] regWriteData = 8'h00;
  logic regRead = 1'b0;
  logic [2:0] interruptCode = 3'h5;
  logic holdTx = 1'b0;
  logic [7:0] regReadData, rdData;
  logic txPending, engineTxBit, busRxPin, busTransmitPin, rxPathBit, txStartAllowed;
  logic ackEnable, errorSignalEnable, ackErrorIgnore, acceptErrorFrames, filterEnable;
  logic errorCounterHold, abortAllTransmissions, sleepActive, clockOutputPin, clockOutputPinEn;
  logic [2:0] currentMode;
  int errCount = 0;
  int testsRun = 0;
  always #12.5 clk = ~clk;
  cmoc_mode_ctrl DUT (
    .clk(clk),
    .reset_n(reset_n),
    .regAddr(regAddr),
    .regWrite(regWrite),
    .regWriteData(regWriteData),
    .regRead(regRead),
    .regReadData(regReadData),
    .interruptCode(interruptCode),
    .txPending(txPending),
    .engineTxBit(engineTxBit),
    .busRxPin(busRxPin),
    .busTransmitPin(busTransmitPin),
    .rxPathBit(rxPathBit),
    .txStartAllowed(txStartAllowed),
    .ackEnable(ackEnable),
    .errorSignalEnable(errorSignalEnable),
    .ackErrorIgnore(ackErrorIgnore),
    .acceptErrorFrames(acceptErrorFrames),
    .filterEnable(filterEnable),
    .errorCounterHold(errorCounterHold),
    .abortAllTransmissions(abortAllTransmissions),
    .sleepActive(sleepActive),
    .currentMode(currentMode),
    .clockOutputPin(clockOutputPin),
    .clockOutputPinEn(clockOutputPinEn)
  );
  cmoc_bus_partner partner (
    .clk(clk),
    .reset_n(reset_n),
    .holdTx(holdTx),
    .busTransmitPin(busTransmitPin),
    .txPending(txPending),
    .engineTxBit(engineTxBit),
    .busRxPin(busRxPin)
  );
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    testsRun++;
    if (seen !== exp) begin
      errCount++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : cycles
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr = a;
    regWriteData = d;
    regWrite = 1'b1;
    cycles(1);
    regWrite = 1'b0;
    // Idle edge so a following request never re-raises a strobe at once
    cycles(1);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    regAddr = a;
    regRead = 1'b1;
    cycles(1);
    regRead = 1'b0;
    rdData = regReadData;
    cycles(1);
  endtask : rd
  // Reset state, checked just after release, before the next edge
  task automatic test_reset;
    check("mode", 8'(currentMode), 8'h04);
    check("clock_output_enable", 8'(clockOutputPinEn), 8'h01);
    rd(8'h3F);
    check("control", rdData, 8'h87);
    rd(8'h0E);
    check("status", rdData, 8'h8A);
    rd(8'h2C);
    check("unmapped", rdData, 8'h00);
  endtask : test_reset
  // Every mode code in turn; bit 3 is written high each time
  task automatic test_modes;
    logic [2:0] m;
    for (int i = 0; i < 5; i++) begin
      m = 3'(i);
      interruptCode = 3'(i + 1);
      wr(8'h0F, {m, 5'h0F});
      cycles(3);
      check("mode", 8'(currentMode), 8'(m));
      check("flags", {txStartAllowed, ackErrorIgnore, acceptErrorFrames, errorCounterHold,
        sleepActive, ackEnable, errorSignalEnable, filterEnable}, {m == 3'h0, m == 3'h2,
        m == 3'h3, m >= 3'h3, m == 3'h1, m == 3'h0, m == 3'h0, 1'b1});
      rd(8'hFF);
      check("control", rdData, {m, 5'h07});
      rd(8'h1E);
      check("status", rdData, {m, 1'b0, 3'(i + 1), 1'b0});
    end
  endtask : test_modes
  // Undefined mode code and a write to the read-only status
  task automatic test_invalid;
    wr(8'h0F, 8'hA4);
    cycles(3);
    check("mode", 8'(currentMode), 8'h04);
    rd(8'h0F);
    check("control", rdData, 8'h84);
    wr(8'h0E, 8'h00);
    rd(8'h0E);
    check("status", rdData, 8'h8A);
  endtask : test_invalid
  // Mode change held off while a transmission is pending
  task automatic test_pending;
    holdTx = 1'b1;
    wr(8'h0F, 8'h07);
    cycles(6);
    check("held", 8'(currentMode), 8'h04);
    check("notx", 8'(txStartAllowed), 8'h00);
    holdTx = 1'b0;
    cycles(3);
    check("moved", 8'(currentMode), 8'h00);
    wr(8'h0F, 8'h87);
    cycles(3);
  endtask : test_pending
  task automatic test_abort;
    wr(8'h0F, 8'h97);
    cycles(1);
    check("abort", 8'(abortAllTransmissions), 8'h01);
    wr(8'h0F, 8'h87);
    cycles(1);
    check("abort", 8'(abortAllTransmissions), 8'h00);
  endtask : test_abort
  // Pin off, then each divider; half periods counted in clk cycles
  task automatic test_clock_output_pin;
    int n;
    wr(8'h0F, 8'h80);
    cycles(20);
    check("clkoff", 8'(clockOutputPinEn), 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr(8'h0F, 8'h84 | 8'(c));
      cycles(20);
      check("clkon", 8'(clockOutputPinEn), 8'h01);
      if (c == 0) begin
        // Undivided: the pin follows the oscillator in both phases
        check("div1high", 8'(clockOutputPin), 8'h01);
        #12.5;
        check("div1low", 8'(clockOutputPin), 8'h00);
        cycles(1);
      end else begin
        while (clockOutputPin !== 1'b0) cycles(1);
        while (clockOutputPin !== 1'b1) cycles(1);
        n = 0;
        while (clockOutputPin === 1'b1) begin
          n++;
          cycles(1);
        end
        check("half", 8'(n), 8'h01 << (c - 1));
      end
    end
  endtask : test_clock_output_pin
  task automatic tally_and_finish;
    if (errCount == 0 && testsRun > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  // Main sequence
  initial begin
    cycles(16);
    reset_n = 1'b1;
    test_reset();
    test_modes();
    test_invalid();
    test_pending();
    test_abort();
    test_clock_output_pin();
    tally_and_finish();
  end
  // Watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    errCount++;
    tally_and_finish();
  end
endmodule : cmoc_mode_ctrl_tb_top
`default_nettype wire
